// file: hml_regs.svh
/*
 * Register offsets, field positions, reset values and codes for the host
 * memory load port. Assumes inclusion by bare name from design files.
 */
`ifndef HML_REGS_SVH
`define HML_REGS_SVH

`define HML_SUB_CFG        7'h00
`define HML_SUB_STAT       7'h02
`define HML_SUB_HDR        7'h04
`define HML_SUB_PAY        7'h05
`define HML_CFG_RESET      32'h00001b22
`define HML_CFG_BYTES      4'h4
`define HML_HDR_BYTES      4'h8
`define HML_GRP_BYTES      4'h8
`define HML_OUT_WS_LSB     8
`define HML_IN_WS_LSB      11
`define HML_MASTER_BIT     22
`define HML_IN_FMT_LSB     4
`define HML_OUT_FMT_LSB    0
`define HML_RD_BIT         7
`define HML_STAT_INVALID   8'h20
`define HML_STAT_END_ERR   8'hf0
`define HML_MEM_MCU_PROG   8'h00
`define HML_MEM_MCU_XDATA  8'h01
`define HML_MEM_DSP_PROG   8'h02
`define HML_MEM_DSP_COEF   8'h03
`define HML_MEM_DSP_DATA   8'h04
`define HML_MEM_DSP_UDATA  8'h05
`define HML_MEM_DSP_UCOEF  8'h06
`define HML_WB_CTRL        5'h00
`define HML_WB_DHI         5'h04
`define HML_WB_DLO         5'h08
`define HML_WB_STAT        5'h0c
`define HML_WB_RDATA       5'h10
`define HML_CMD_BITS       7'h08
`define HML_RD_BITS        7'h20

`endif

// file: hml_pkg.sv
/*
 * Types shared by both ends of the host memory load port.
 * Assumes nothing of its surroundings.
 */
package hml_pkg;
  typedef enum {LD_IDLE, LD_DATA, LD_SUM} hml_load_e;
  typedef enum {H_IDLE, H_LOW, H_HIGH, H_STOP} hml_host_e;
  typedef logic [7:0] hml_byte_t;
endpackage

// file: hml_link_if.sv
/*
 * Serial link between the load controller and the device.
 * Assumes both ends run on their own clocks; every signal is one-directional.
 */
`timescale 1ns/1ps
interface hml_link_if;
  logic scl;
  logic frame_n;
  logic mosi;
  logic miso;
  modport host (output scl, output frame_n, output mosi, input miso);
  modport dev  (input scl, input frame_n, input mosi, output miso);
endinterface

// file: hml_sync.sv
/*
 * Two flip-flop synchroniser for a group of independent levels.
 * Assumes each bit is a level from outside the clock domain.
 */
`timescale 1ns/1ps
module hml_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clock_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      meta_q <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule // hml_sync

// file: hml_dev_end.sv
/*
 * Device end: clock/port configuration, load status and the memory load
 * engine behind a serial register link.
 * Assumes the host makes the link clock; firmware clears flags synchronously.
 */
`timescale 1ns/1ps
`include "hml_regs.svh"

// What this block does
// - Output word size from config bits 9:8
// - Input word size from config bits 12:11
// - Bit 22 picks crystal master or slave
// - Input format bits 7:4, output 3:0
// - Config resets to 0x00001b22
// - Load start or error sets flag of memory 0, 1, 2, 5 or 6
// - Successful load clears memory flag
// - Host checks status after each load
// - Firmware may clear status flags
// - Status low byte flags memories 0, 1, 2, 5, 6
// - Header is eight bytes, fixed layout
// - Payload written up to eight bytes per write
// - Header write starts load, payload after
// - Host appends two checksum bytes last
// - After checksum, post result in status
// - Checksum over the last six header bytes and payload bytes
// - Decode target memory code 0..6
// - Address and count are 16-bit fields
// - Payload packing depends on word size
module hml_dev_end
  import hml_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  hml_link_if.dev          link,
  input  wire logic [7:0]  fw_clear_in,
  output logic             crystal_source_out,
  output logic [5:0]       out_word_bits_out,
  output logic [5:0]       in_word_bits_out,
  output logic [3:0]       input_format_field_out,
  output logic [3:0]       output_format_field_out,
  output logic [7:0]       load_status_out,
  output logic             load_busy_out,
  output logic             mem_we_out,
  output logic [7:0]       mem_sel_out,
  output logic [15:0]      mem_addr_out,
  output logic [53:0]      mem_data_out
);
  function automatic logic [5:0] ws_bits(input logic [1:0] f);
    unique case (f)
      2'h0: ws_bits = 6'h20;
      2'h1: ws_bits = 6'h10;
      2'h2: ws_bits = 6'h14;
      2'h3: ws_bits = 6'h18;
    endcase
  endfunction

  function automatic logic [7:0] flag_of(input logic [7:0] code);
    case (code)
      `HML_MEM_MCU_PROG:  flag_of = 8'h01;
      `HML_MEM_MCU_XDATA: flag_of = 8'h02;
      `HML_MEM_DSP_PROG:  flag_of = 8'h04;
      `HML_MEM_DSP_UCOEF: flag_of = 8'h08;
      `HML_MEM_DSP_UDATA: flag_of = 8'h10;
      default:            flag_of = 8'h00;
    endcase
  endfunction

  function automatic logic [3:0] last_byte(input logic [7:0] code);
    case (code)
      `HML_MEM_MCU_PROG, `HML_MEM_MCU_XDATA: last_byte = 4'h0;
      `HML_MEM_DSP_COEF, `HML_MEM_DSP_UCOEF: last_byte = 4'h3;
      default:                               last_byte = 4'h7;
    endcase
  endfunction

  function automatic logic [55:0] word_mask(input logic [7:0] code);
    case (code)
      `HML_MEM_MCU_PROG, `HML_MEM_MCU_XDATA: word_mask = 56'h00000000_0000ff;
      `HML_MEM_DSP_COEF, `HML_MEM_DSP_UCOEF: word_mask = 56'h00000000_ffffff | 56'h0f000000;
      `HML_MEM_DSP_PROG:                     word_mask = 56'h3fffff_ffffffff;
      default:                               word_mask = 56'h00ffff_ffffffff;
    endcase
  endfunction

  function automatic logic [15:0] hdr_sum(input logic [47:0] b);
    logic [15:0] s;
    s = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      s = s + {8'h00, b[i*8 +: 8]};
    end
    hdr_sum = s;
  endfunction

  logic        scl_s, frame_n_s, mosi_s;
  logic        scl_prev_q;
  logic [2:0]  bit_cnt_q;
  logic [6:0]  shift_q;
  logic [3:0]  byte_idx_q;
  hml_byte_t   cmd_q;
  logic        rd_active_q;
  logic [31:0] rd_sh_q;
  logic        miso_q;
  logic [23:0] cfg_sh_q;
  logic [31:0] cfg_q;
  logic [55:0] hdr_sh_q;
  hml_load_e   state_q;
  hml_byte_t   mem_q;
  logic [15:0] csum_q, addr_q, remain_q, sum_q;
  logic [47:0] word_q;
  logic [3:0]  wbyte_q;
  logic        ck_first_q;
  hml_byte_t   ck_hi_q;
  logic [7:0]  stat_q;

  hml_sync #(.W(3), .RST_VAL(3'b010)) u_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .d_in     ({link.scl, link.frame_n, link.mosi}),
    .q_out    ({scl_s, frame_n_s, mosi_s})
  );

  logic        rise, fall, byte_strobe, wr_byte, hdr_go, pay_go, word_end;
  hml_byte_t   byte_val;
  logic [63:0] hdr_w;
  logic [55:0] word_next;
  logic [7:0]  st_set, st_clr;

  always_comb begin
    rise        = scl_s && !scl_prev_q && !frame_n_s;
    fall        = !scl_s && scl_prev_q && !frame_n_s;
    byte_strobe = rise && (bit_cnt_q == 3'h7);
    byte_val    = {shift_q, mosi_s};
    wr_byte     = byte_strobe && (byte_idx_q != 4'h0) && !cmd_q[`HML_RD_BIT];
    hdr_w       = {hdr_sh_q, byte_val};
    hdr_go      = wr_byte && (cmd_q[6:0] == `HML_SUB_HDR) && (byte_idx_q == `HML_HDR_BYTES);
    pay_go      = wr_byte && (cmd_q[6:0] == `HML_SUB_PAY) && (byte_idx_q <= `HML_GRP_BYTES);
    word_end    = (wbyte_q == last_byte(mem_q));
    word_next   = {word_q, byte_val} & word_mask(mem_q);
  end

  // Link side: bit and byte framing, register read shift-out
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      scl_prev_q  <= 1'b0;
      bit_cnt_q   <= 3'h0;
      shift_q     <= 7'h00;
      byte_idx_q  <= 4'h0;
      cmd_q       <= 8'h00;
      rd_active_q <= 1'b0;
      rd_sh_q     <= 32'h0;
      miso_q      <= 1'b0;
    end else begin
      scl_prev_q <= scl_s;
      if (frame_n_s) begin
        bit_cnt_q   <= 3'h0;
        byte_idx_q  <= 4'h0;
        rd_active_q <= 1'b0;
      end else if (rise) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        shift_q   <= byte_val[6:0];
        if (byte_strobe) begin
          byte_idx_q <= (byte_idx_q == 4'hf) ? byte_idx_q : byte_idx_q + 4'h1;
          if (byte_idx_q == 4'h0) begin
            cmd_q       <= byte_val;
            rd_active_q <= byte_val[`HML_RD_BIT];
            if (byte_val[6:0] == `HML_SUB_CFG) begin
              rd_sh_q <= cfg_q;
            end else if (byte_val[6:0] == `HML_SUB_STAT) begin
              rd_sh_q <= {24'h0, stat_q};
            end else begin
              rd_sh_q <= 32'h0;
            end
          end
        end
      end else if (fall && rd_active_q) begin
        miso_q  <= rd_sh_q[31];
        rd_sh_q <= {rd_sh_q[30:0], 1'b0};
      end
    end
  end

  assign link.miso = miso_q;

  // Clock and serial audio port configuration
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cfg_sh_q <= 24'h0;
      cfg_q    <= `HML_CFG_RESET;
    end else if (wr_byte && (cmd_q[6:0] == `HML_SUB_CFG)) begin
      cfg_sh_q <= {cfg_sh_q[15:0], byte_val};
      if (byte_idx_q == `HML_CFG_BYTES) begin
        cfg_q <= {cfg_sh_q, byte_val};
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      crystal_source_out      <= 1'b0;
      out_word_bits_out       <= 6'h00;
      in_word_bits_out        <= 6'h00;
      input_format_field_out  <= 4'h0;
      output_format_field_out <= 4'h0;
    end else begin
      crystal_source_out      <= cfg_q[`HML_MASTER_BIT];
      out_word_bits_out       <= ws_bits(cfg_q[`HML_OUT_WS_LSB +: 2]);
      in_word_bits_out        <= ws_bits(cfg_q[`HML_IN_WS_LSB +: 2]);
      input_format_field_out  <= cfg_q[`HML_IN_FMT_LSB +: 4];
      output_format_field_out <= cfg_q[`HML_OUT_FMT_LSB +: 4];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      hdr_sh_q <= 56'h0;
    end else if (wr_byte && (cmd_q[6:0] == `HML_SUB_HDR)) begin
      hdr_sh_q <= hdr_w[55:0];
    end
  end

  // Load engine
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q      <= LD_IDLE;
      mem_q        <= 8'h00;
      csum_q       <= 16'h0;
      addr_q       <= 16'h0;
      remain_q     <= 16'h0;
      sum_q        <= 16'h0;
      word_q       <= 48'h0;
      wbyte_q      <= 4'h0;
      ck_first_q   <= 1'b0;
      ck_hi_q      <= 8'h00;
      mem_we_out   <= 1'b0;
      mem_sel_out  <= 8'h00;
      mem_addr_out <= 16'h0;
      mem_data_out <= 54'h0;
    end else begin
      mem_we_out <= 1'b0;
      if (hdr_go) begin
        csum_q   <= hdr_w[63:48];
        mem_q    <= hdr_w[47:40];
        addr_q   <= hdr_w[31:16];
        remain_q <= hdr_w[15:0];
        sum_q    <= hdr_sum(hdr_w[47:0]);
        wbyte_q  <= 4'h0;
        if ((hdr_w[15:0] != 16'h0) && (hdr_w[47:40] <= `HML_MEM_DSP_UCOEF)) begin
          state_q <= LD_DATA;
        end else begin
          state_q <= LD_IDLE;
        end
      end else if (pay_go) begin
        unique case (state_q)
          LD_IDLE: begin
          end
          LD_DATA: begin
            sum_q    <= sum_q + {8'h00, byte_val};
            word_q   <= word_next[47:0];
            remain_q <= remain_q - 16'h1;
            if (word_end) begin
              wbyte_q      <= 4'h0;
              addr_q       <= addr_q + 16'h1;
              mem_we_out   <= 1'b1;
              mem_sel_out  <= mem_q;
              mem_addr_out <= addr_q;
              mem_data_out <= word_next[53:0];
            end else begin
              wbyte_q <= wbyte_q + 4'h1;
            end
            if (remain_q == 16'h1) begin
              state_q    <= LD_SUM;
              ck_first_q <= 1'b1;
            end
          end
          LD_SUM: begin
            ck_first_q <= 1'b0;
            ck_hi_q    <= byte_val;
            if (!ck_first_q) begin
              state_q <= LD_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Status flags; a hardware set wins over any clear in the same cycle
  always_comb begin
    st_set = 8'h00;
    st_clr = 8'h00;
    if (hdr_go) begin
      if (hdr_w[15:0] == 16'h0) begin
        if ((hdr_w[63:48] != 16'h0) || (hdr_w[31:16] != 16'h0)) begin
          st_clr = 8'hff;
          st_set = `HML_STAT_END_ERR;
        end
      end else if (hdr_w[47:40] > `HML_MEM_DSP_UCOEF) begin
        st_set = `HML_STAT_INVALID;
      end else begin
        st_set = flag_of(hdr_w[47:40]);
      end
    end else if (pay_go && (state_q == LD_SUM) && !ck_first_q) begin
      if (({ck_hi_q, byte_val} == sum_q) && ({ck_hi_q, byte_val} == csum_q)) begin
        st_clr = flag_of(mem_q);
      end else begin
        st_set = flag_of(mem_q);
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      stat_q          <= 8'h00;
      load_status_out <= 8'h00;
      load_busy_out   <= 1'b0;
    end else begin
      stat_q          <= (stat_q & ~(st_clr | fw_clear_in)) | st_set;
      load_status_out <= stat_q;
      load_busy_out   <= (state_q != LD_IDLE);
    end
  end
endmodule // hml_dev_end

// file: hml_host_end.sv
/*
 * Host end: load controller driven by software over classic Wishbone,
 * sending register writes and reads over the serial link.
 * Assumes software checks the device status after every load.
 */
`timescale 1ns/1ps
`include "hml_regs.svh"

module hml_host_end
  import hml_pkg::*;
#(
  parameter int SCL_HALF = 4
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  hml_link_if.host         link,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [4:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic [3:0]  wb_sel_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out
);
  localparam logic [7:0] HALF_M1 = 8'(SCL_HALF - 1);

  hml_host_e   state_q;
  logic [31:0] ctrl_q, dhi_q, dlo_q, rdata_q;
  logic [71:0] tx_q;
  logic [6:0]  bit_idx_q, total_q;
  logic [7:0]  div_q;
  logic        scl_q, frame_n_q, mosi_q, miso_s;
  logic        req, wr_go;

  hml_sync #(.W(1), .RST_VAL(1'b0)) u_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .d_in     (link.miso),
    .q_out    (miso_s)
  );

  always_comb begin
    req   = wb_cyc_in && wb_stb_in;
    wr_go = req && wb_ack_out && wb_we_in;
  end

  // Wishbone slave: one wait state, write takes effect on the acked edge
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
      dhi_q      <= 32'h0;
      dlo_q      <= 32'h0;
    end else begin
      wb_ack_out <= req && !wb_ack_out;
      if (req && !wb_ack_out) begin
        unique case (wb_adr_in)
          `HML_WB_CTRL:  wb_dat_out <= ctrl_q;
          `HML_WB_DHI:   wb_dat_out <= dhi_q;
          `HML_WB_DLO:   wb_dat_out <= dlo_q;
          `HML_WB_STAT:  wb_dat_out <= {31'h0, state_q != H_IDLE};
          `HML_WB_RDATA: wb_dat_out <= rdata_q;
          default:       wb_dat_out <= 32'h0;
        endcase
      end
      for (int i = 0; i < 4; i++) begin
        if (wr_go && wb_sel_in[i] && (wb_adr_in == `HML_WB_DHI)) begin
          dhi_q[i*8 +: 8] <= wb_dat_in[i*8 +: 8];
        end
        if (wr_go && wb_sel_in[i] && (wb_adr_in == `HML_WB_DLO)) begin
          dlo_q[i*8 +: 8] <= wb_dat_in[i*8 +: 8];
        end
      end
    end
  end

  // Link sequencer; a new command is ignored while one is in flight
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q   <= H_IDLE;
      ctrl_q    <= 32'h0;
      tx_q      <= 72'h0;
      bit_idx_q <= 7'h00;
      total_q   <= 7'h00;
      div_q     <= 8'h00;
      scl_q     <= 1'b0;
      frame_n_q <= 1'b1;
      mosi_q    <= 1'b0;
      rdata_q   <= 32'h0;
    end else begin
      div_q <= (div_q == HALF_M1) ? 8'h00 : div_q + 8'h01;
      unique case (state_q)
        H_IDLE: begin
          div_q <= 8'h00;
          if (wr_go && (wb_adr_in == `HML_WB_CTRL)) begin
            ctrl_q    <= wb_dat_in;
            tx_q      <= {wb_dat_in[7:0], dhi_q, dlo_q};
            mosi_q    <= wb_dat_in[7];
            frame_n_q <= 1'b0;
            bit_idx_q <= 7'h00;
            if (wb_dat_in[`HML_RD_BIT]) begin
              total_q <= `HML_CMD_BITS + `HML_RD_BITS;
            end else if (wb_dat_in[11:8] > `HML_GRP_BYTES) begin
              total_q <= `HML_CMD_BITS + 7'h40;
            end else begin
              total_q <= `HML_CMD_BITS + {wb_dat_in[11:8], 3'h0};
            end
            state_q <= H_LOW;
          end
        end
        H_LOW: begin
          if (div_q == HALF_M1) begin
            scl_q   <= 1'b1;
            state_q <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (div_q == HALF_M1) begin
            scl_q     <= 1'b0;
            bit_idx_q <= bit_idx_q + 7'h01;
            tx_q      <= {tx_q[70:0], 1'b0};
            mosi_q    <= tx_q[70];
            if (bit_idx_q >= `HML_CMD_BITS) begin
              rdata_q <= {rdata_q[30:0], miso_s};
            end
            state_q <= (bit_idx_q == total_q - 7'h01) ? H_STOP : H_LOW;
          end
        end
        H_STOP: begin
          if (div_q == HALF_M1) begin
            frame_n_q <= 1'b1;
            state_q   <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.scl     = scl_q;
  assign link.frame_n = frame_n_q;
  assign link.mosi    = mosi_q;
endmodule // hml_host_end

// file: hml_link_props.sv
/*
 * Checker for the serial link between host end and device end.
 * Assumes one clock for both ends and SCL_HALF of 4 at the host end.
 */
`timescale 1ns/1ps
module hml_link_props (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic scl,
  input wire logic frame_n,
  input wire logic mosi,
  input wire logic miso
);
  logic [7:0] rises_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // Counts link clock rises within the current frame
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || frame_n) begin
      rises_q <= 8'h00;
    end else if ($rose(scl)) begin
      rises_q <= rises_q + 8'h01;
    end
  end

  chk_scl_in_frame: assert property (frame_n |-> !scl)
    else $error("link clock high outside a frame");
  chk_mosi_high_stable: assert property (scl && $past(scl) |-> $stable(mosi))
    else $error("host data moved while link clock high");
  chk_miso_high_stable: assert property (scl && $past(scl) |-> $stable(miso))
    else $error("device data moved while link clock high");
  chk_scl_high_width: assert property ($rose(scl) |-> scl [*4] ##1 !scl)
    else $error("link clock high phase not four cycles");
  chk_scl_low_width: assert property ($fell(scl) |-> !scl [*4])
    else $error("link clock low phase shorter than four cycles");
  chk_first_bit_setup: assert property ($fell(frame_n) |-> !scl [*4] ##1 scl)
    else $error("first link clock rise not four cycles after frame start");
  chk_frame_bounded: assert property ($fell(frame_n) |-> ##[1:700] frame_n)
    else $error("frame did not end in time");
  chk_frame_whole_bytes: assert property ($rose(frame_n) |-> rises_q[2:0] == 3'h0 && rises_q >= 8'h08)
    else $error("frame not a whole number of bytes");
  chk_reset_idle_level: assert property ($rose(rst_n_in) |-> frame_n && !scl)
    else $error("link not idle after reset");

  cov_frame: cover property ($rose(frame_n));
  cov_header_frame: cover property ($rose(frame_n) && rises_q == 8'h48);
  cov_read_bit: cover property (!frame_n && $rose(miso));
endmodule // hml_link_props

// file: testbench.sv
/*
 * Self-checking bench: software writes over Wishbone to the host end, which
 * drives the device end over the link. Assumes a 50 MHz clock.
 */
`timescale 1ns/1ps
`include "hml_regs.svh"
module testbench;
  import hml_pkg::*;
  logic        clock_in = 0, rst_n_in = 0, cyc = 0, stb = 0, we = 0;
  logic [4:0]  adr = '0;
  logic [31:0] wdat = '0, wb_dat, q, cfg;
  logic [3:0]  sel = '0;
  logic [7:0]  fw_clr = '0, stat, mem_sel;
  logic        wb_ack, crystal, busy, mem_we;
  logic [5:0]  out_bits, in_bits;
  logic [3:0]  in_fmt, out_fmt;
  logic [15:0] mem_addr;
  logic [53:0] mem_data;
  logic [15:0] wa[$];
  logic [53:0] wd[$];
  logic [7:0]  wsel[$];
  int          n_errors = 0, checks_done = 0;

  always #10 clock_in = ~clock_in;

  hml_link_if link ();
  hml_host_end #(.SCL_HALF(4)) hml_host_end_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(link),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel),
    .wb_dat_out(wb_dat), .wb_ack_out(wb_ack));
  hml_dev_end hml_dev_end_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(link), .fw_clear_in(fw_clr),
    .crystal_source_out(crystal), .out_word_bits_out(out_bits), .in_word_bits_out(in_bits),
    .input_format_field_out(in_fmt), .output_format_field_out(out_fmt), .load_status_out(stat),
    .load_busy_out(busy), .mem_we_out(mem_we), .mem_sel_out(mem_sel), .mem_addr_out(mem_addr),
    .mem_data_out(mem_data));
  hml_link_props hml_link_props_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .scl(link.scl),
    .frame_n(link.frame_n), .mosi(link.mosi), .miso(link.miso));

  // Records every memory word write
  always @(posedge clock_in) begin
    if (mem_we === 1'b1) begin
      wa.push_back(mem_addr);
      wd.push_back(mem_data);
      wsel.push_back(mem_sel);
    end
  end

  task automatic end_sim;
    $display("counts: mismatches %0d comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb_cycle(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    // Ack and read data are taken as sampled at the rising edge, then released
    do begin
      @(posedge clock_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 100);
    if (n >= 100) n_errors++;
    r = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // One link frame: data words, command, wait for idle, fetch read data
  task automatic dev_xfer(input logic rd, input logic [6:0] sub, input logic [3:0] cnt, input logic [63:0] d,
                          output logic [31:0] r);
    int n;
    n = 0;
    wb_cycle(1'b1, `HML_WB_DHI, d[63:32], r);
    wb_cycle(1'b1, `HML_WB_DLO, d[31:0], r);
    wb_cycle(1'b1, `HML_WB_CTRL, {20'h0, cnt, rd, sub}, r);
    do begin
      wb_cycle(1'b0, `HML_WB_STAT, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 1000);
    if (n >= 1000) n_errors++;
    wb_cycle(1'b0, `HML_WB_RDATA, 32'h0, r);
  endtask

  function automatic logic [15:0] bsum(input logic [63:0] g, input int n);
    logic [15:0] s;
    s = 16'h0;
    for (int k = 0; k < n; k++) s = s + 16'(g[63-8*k -: 8]);
    return s;
  endfunction

  function automatic logic [5:0] wbits(input int c);
    case (c)
      0: return 6'h20;
      1: return 6'h10;
      2: return 6'h14;
      default: return 6'h18;
    endcase
  endfunction

  // Header, payload with trailing checksum (xor bad to corrupt it), status checks
  task automatic load(input logic [7:0] code, input logic [15:0] a, input logic [15:0] c, input logic [63:0] p,
                      input logic [15:0] bad, input logic [7:0] end_exp);
    logic [15:0] s;
    logic [31:0] r;
    s = bsum({code, 8'h0, a, c, 16'h0}, 6) + bsum(p, int'(c));
    wa.delete(); wd.delete(); wsel.delete();
    dev_xfer(1'b0, 7'h04, 4'h8, {s, code, 8'h0, a, c}, r);
    check(stat, 8'h01 << code[2:0]);
    check(busy, 1'b1);
    if (c == 16'h0004) dev_xfer(1'b0, 7'h05, 4'h8, {p[63:32], s ^ bad, 16'h0}, r);
    else begin
      dev_xfer(1'b0, 7'h05, 4'h8, p, r);
      dev_xfer(1'b0, 7'h05, 4'h8, {s ^ bad, 48'h0}, r);
    end
    check(stat, end_exp);
    dev_xfer(1'b1, 7'h02, 4'h4, 64'h0, r);
    check(r, {24'h0, end_exp});
  endtask

  initial begin
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    @(negedge clock_in);
    check(crystal, 1'b0);
    check(out_bits, 6'h18);
    check(in_bits, 6'h18);
    check({in_fmt, out_fmt}, 8'h22);
    dev_xfer(1'b1, 7'h00, 4'h4, 64'h0, q);
    check(q, 32'h00001b22);
    dev_xfer(1'b1, 7'h02, 4'h4, 64'h0, q);
    check(q, 32'h0);
    $display("test reset done");

    for (int i = 0; i < 4; i++) begin
      cfg = 32'h0;
      cfg[22] = i[0];
      cfg[9:8] = 2'(i);
      cfg[12:11] = 2'(3 - i);
      cfg[7:4] = 4'(i + 4);
      cfg[3:0] = 4'(i + 8);
      dev_xfer(1'b0, 7'h00, 4'h4, {cfg, 32'h0}, q);
      check(out_bits, wbits(i));
      check(in_bits, wbits(3 - i));
      check(crystal, i[0]);
      check({in_fmt, out_fmt}, {4'(i + 4), 4'(i + 8)});
      dev_xfer(1'b1, 7'h00, 4'h4, 64'h0, q);
      check(q, cfg);
    end
    $display("test config done");

    load(8'h00, 16'h0010, 16'h0004, {32'ha1b2c3d4, 32'h0}, 16'h0, 8'h00);
    check(wa.size(), 4);
    for (int k = 0; k < 4; k++) begin
      check(wa[k], 16'h0010 + 16'(k));
      check(wd[k], 54'(8'ha1 + 8'(k * 8'h11)));
      check(wsel[k], 8'h00);
    end
    $display("test byte load done");

    load(8'h02, 16'h0100, 16'h0008, 64'h002a123456789abc, 16'h0001, 8'h04);
    check(wa[0], 16'h0100);
    check(wd[0], 54'h2a123456789abc);
    @(posedge clock_in);
    fw_clr <= 8'h04;
    @(posedge clock_in);
    fw_clr <= 8'h00;
    repeat (3) @(posedge clock_in);
    check(stat, 8'h00);
    $display("test bad checksum done");

    wa.delete();
    dev_xfer(1'b0, 7'h04, 4'h8, {16'h000d, 8'h09, 8'h0, 16'h0000, 16'h0004}, q);
    check(stat, 8'h20);
    dev_xfer(1'b0, 7'h04, 4'h8, 64'h0, q);
    check(stat, 8'h20);
    check(wa.size(), 0);
    dev_xfer(1'b0, 7'h04, 4'h8, {16'h1234, 8'h01, 8'h0, 16'h0005, 16'h0000}, q);
    check(stat, 8'hf0);
    dev_xfer(1'b1, 7'h02, 4'h4, 64'h0, q);
    check(q, 32'h000000f0);
    $display("test headers done");

    wb_cycle(1'b1, 5'h14, 32'hdeadbeef, q);
    wb_cycle(1'b0, 5'h14, 32'h0, q);
    check(q, 32'h0);
    $display("test unmapped done");
    end_sim();
  end

  initial begin
    #2000000;
    n_errors++;
    end_sim();
  end
endmodule // testbench
